// ### core/sxt_pkg.sv
`default_nettype none
package sxt_pkg;
  // ****************************************
  // register port map
  // ****************************************
  localparam logic [4:0] SXT_RA_DREG0 = 5'h00; // data registers 0..7
  localparam logic [4:0] SXT_RA_AREG0 = 5'h08; // address registers 8..15
  localparam logic [4:0] SXT_RA_CCR   = 5'h10; // condition flags
  localparam logic [4:0] SXT_CCR_RST  = 5'h00;
  localparam logic [31:0] SXT_WORD_RST = 32'h0000_0000;

  // ****************************************
  // condition flag positions
  // ****************************************
  localparam int SXT_CC_BCOPY  = 4; // borrow_copy_flag
  localparam int SXT_CC_MSB    = 3; // msb_flag
  localparam int SXT_CC_EQ     = 2; // equal_flag
  localparam int SXT_CC_SERR   = 1; // signed_error_flag
  localparam int SXT_CC_BORROW = 0; // borrow_flag

  // ****************************************
  // instruction fields
  // ****************************************
  localparam logic [1:0] SXT_SZ_BYTE = 2'h0;
  localparam logic [1:0] SXT_SZ_WORD = 2'h1;
  localparam logic [1:0] SXT_SZ_LONG = 2'h2;
  localparam logic [1:0] SXT_SZ_BAD  = 2'h3;
  localparam logic [2:0] SXT_M_DREG  = 3'h0;
  localparam logic [2:0] SXT_M_AREG  = 3'h1;
  localparam logic [2:0] SXT_M_EXT   = 3'h7;
  localparam logic [2:0] SXT_X_ABSL  = 3'h1; // highest legal register code in mode 7
  localparam logic [7:0] SXT_OPC_SUB_IMMEDIATE  = 8'h04;    // bits 15..8
  localparam logic [3:0] SXT_OPC_QUICK = 4'h5;     // bits 15..12, bit 8 high
  localparam logic [3:0] SXT_OPC_SUB_WITH_CARRY  = 4'h9;     // bits 15..12, bit 8 high, 5..4 zero
  localparam logic [12:0] SXT_OPC_XCHG = 13'h0908; // bits 15..3
  localparam logic [9:0] SXT_OPC_TAS   = 10'h12b;  // bits 15..6
  localparam logic [2:0] SXT_QUICK_ZERO = 3'h0;
  localparam logic [31:0] SXT_QUICK_EIGHT = 32'h0000_0008;
  localparam int SXT_TAS_BIT = 7;

  typedef enum logic [2:0] {
    OP_SUB_IMMEDIATE = 3'b000,
    OP_SUB_QUICK = 3'b001,
    OP_SUB_WITH_CARRY = 3'b010,
    OP_XCHG = 3'b011,
    OP_TAS  = 3'b100
  } sxt_op_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_EXEC   = 3'b001,
    ST_RD_SRC = 3'b010,
    ST_RD_DST = 3'b011,
    ST_WR     = 3'b100
  } sxt_state_e;
endpackage
`default_nettype wire

// ### core/sxt_alu.sv
`timescale 1ns/1ps
`default_nettype none
module sxt_alu (
  input  wire logic [1:0]  size,
  input  wire logic [31:0] src,
  input  wire logic [31:0] dst,
  input  wire logic        borrow_in,
  output logic      [31:0] diff,
  output logic             neg,
  output logic             zero,
  output logic             ovf,
  output logic             borrow
);
  import sxt_pkg::*;

  logic [8:0]  d8;
  logic [16:0] d16;
  logic [32:0] d32;

  // ****************************************
  // sized subtract, dst - src - borrow_in
  // ****************************************
  // all three widths are formed at once; the size picks one, which keeps
  // the borrow and overflow taps at the true top bit of the operand
  always_comb begin
    d8  = {1'b0, dst[7:0]} - {1'b0, src[7:0]} - {8'h00, borrow_in};
    d16 = {1'b0, dst[15:0]} - {1'b0, src[15:0]} - {16'h0000, borrow_in};
    d32 = {1'b0, dst} - {1'b0, src} - {32'h0000_0000, borrow_in};
    case (size)
      SXT_SZ_BYTE: begin
        diff   = {24'h00_0000, d8[7:0]};
        neg    = d8[7];
        zero   = (d8[7:0] == 8'h00);
        ovf    = (dst[7] ^ src[7]) & (d8[7] ^ dst[7]);
        borrow = d8[8];
      end
      SXT_SZ_WORD: begin
        diff   = {16'h0000, d16[15:0]};
        neg    = d16[15];
        zero   = (d16[15:0] == 16'h0000);
        ovf    = (dst[15] ^ src[15]) & (d16[15] ^ dst[15]);
        borrow = d16[16];
      end
      default: begin
        diff   = d32[31:0];
        neg    = d32[31];
        zero   = (d32[31:0] == 32'h0000_0000);
        ovf    = (dst[31] ^ src[31]) & (d32[31] ^ dst[31]);
        borrow = d32[32];
      end
    endcase
  end
endmodule
`default_nettype wire

// ### core/sxt_exec.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sxt_exec (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [15:0] ext_word0,
  input  wire logic [15:0] ext_word1,
  input  wire logic [31:0] ea_addr,
  output logic             mem_rd_ff,
  output logic             mem_wr_ff,
  output logic             mem_lock_ff,
  output logic      [1:0]  mem_size_ff,
  output logic      [31:0] mem_addr_ff,
  output logic      [31:0] mem_wdata_ff,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_berr,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_ff,
  output logic      [4:0]  ccr_ff,
  output logic             busy_ff,
  output logic             done_ff,
  output logic             illegal_ff,
  output logic             bus_err_ff
);
  import sxt_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      SXT_SZ_BYTE: size_bytes = 32'h0000_0001;
      SXT_SZ_WORD: size_bytes = 32'h0000_0002;
      default:     size_bytes = 32'h0000_0004;
    endcase
  endfunction

  // only the sized low part changes, the rest of the register stays
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [1:0] sz);
    case (sz)
      SXT_SZ_BYTE: merge = {old[31:8], nw[7:0]};
      SXT_SZ_WORD: merge = {old[31:16], nw[15:0]};
      default:     merge = nw;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  sxt_state_e  state_ff;
  sxt_op_e     op_ff;
  logic [1:0]  size_ff;
  logic [31:0] src_ff;
  logic [31:0] dst_ff;
  logic        dst_dreg_ff;
  logic        dst_areg_ff;
  logic [2:0]  dst_idx_ff;
  logic [4:0]  pend_ccr_ff;
  logic [31:0] dreg_ff [8];
  logic [31:0] areg_ff [8];

  // ****************************************
  // decode of the offered instruction
  // ****************************************
  logic [1:0]  f_sz;
  logic [2:0]  f_mode;
  logic [2:0]  f_reg;
  logic [2:0]  f_hi;
  logic        f_rm;
  logic        is_sub_immediate;
  logic        is_sub_quick;
  logic        is_sub_with_carry;
  logic        is_xchg;
  logic        is_tas;
  logic        alt_ok;
  logic        dec_ok;
  logic        accept;
  logic        to_dreg;
  logic        to_areg;
  logic [31:0] nxt_imm;
  logic [31:0] nxt_quick;

  assign f_sz   = instr_word[7:6];
  assign f_mode = instr_word[5:3];
  assign f_reg  = instr_word[2:0];
  assign f_hi   = instr_word[11:9];
  assign f_rm   = instr_word[3];

  // opcode classes
  assign is_sub_immediate = (instr_word[15:8] == SXT_OPC_SUB_IMMEDIATE);
  assign is_sub_quick = (instr_word[15:12] == SXT_OPC_QUICK) & instr_word[8];
  assign is_sub_with_carry = (instr_word[15:12] == SXT_OPC_SUB_WITH_CARRY) & instr_word[8]
                 & (instr_word[5:4] == 2'b00);
  assign is_xchg = (instr_word[15:3] == SXT_OPC_XCHG);
  assign is_tas  = (instr_word[15:6] == SXT_OPC_TAS);

  // pc-relative and immediate codes of mode 7 can never be written
  assign alt_ok = (f_mode != SXT_M_EXT) | (f_reg <= SXT_X_ABSL);

  // legality per class; anything else falls through as illegal
  assign dec_ok = (is_sub_immediate & (f_sz != SXT_SZ_BAD) & (f_mode != SXT_M_AREG) & alt_ok)
                | (is_sub_quick & (f_sz != SXT_SZ_BAD) & alt_ok
                   & !((f_mode == SXT_M_AREG) & (f_sz == SXT_SZ_BYTE)))
                | (is_sub_with_carry & (f_sz != SXT_SZ_BAD))
                | is_xchg
                | (is_tas & (f_mode != SXT_M_AREG) & alt_ok);

  assign accept = (state_ff == ST_IDLE) & instr_valid & dec_ok;

  // destination class: registers finish in one exec cycle, others go to the bus
  assign to_dreg = is_xchg | (is_sub_with_carry & !f_rm)
                 | ((is_sub_immediate | is_sub_quick | is_tas) & (f_mode == SXT_M_DREG));
  assign to_areg = is_sub_quick & (f_mode == SXT_M_AREG);

  // immediate operand width follows the size code
  always_comb begin
    case (f_sz)
      SXT_SZ_BYTE: nxt_imm = {24'h00_0000, ext_word0[7:0]};
      SXT_SZ_WORD: nxt_imm = {16'h0000, ext_word0};
      default:     nxt_imm = {ext_word0, ext_word1};
    endcase
  end

  // code 0 stands for 8; sign extension of 1..8 is a zero fill
  assign nxt_quick = (f_hi == SXT_QUICK_ZERO) ? SXT_QUICK_EIGHT
                                              : {29'h0000_0000, f_hi};

  // ****************************************
  // arithmetic and flags
  // ****************************************
  logic [31:0] alu_dst;
  logic [31:0] alu_diff;
  logic        alu_n;
  logic        alu_z;
  logic        alu_v;
  logic        alu_c;
  logic [31:0] nxt_res;
  logic [4:0]  nxt_ccr;

  // memory destinations are fed straight from the read data on its ack
  assign alu_dst = (state_ff == ST_RD_DST) ? mem_rdata : dst_ff;

  sxt_alu u_alu (
    .size      (size_ff),
    .src       (src_ff),
    .dst       (alu_dst),
    .borrow_in ((op_ff == OP_SUB_WITH_CARRY) & ccr_ff[SXT_CC_BCOPY]),
    .diff      (alu_diff),
    .neg       (alu_n),
    .zero      (alu_z),
    .ovf       (alu_v),
    .borrow    (alu_c)
  );

  // result per operation
  always_comb begin
    case (op_ff)
      OP_XCHG: nxt_res = {alu_dst[15:0], alu_dst[31:16]};
      OP_TAS:  nxt_res = alu_dst | (32'h0000_0001 << SXT_TAS_BIT);
      default: nxt_res = alu_diff;
    endcase
  end

  // flag update per operation
  always_comb begin
    nxt_ccr = ccr_ff;
    case (op_ff)
      OP_SUB_IMMEDIATE, OP_SUB_QUICK: begin
        if (!dst_areg_ff) begin
          nxt_ccr[SXT_CC_MSB]    = alu_n;
          nxt_ccr[SXT_CC_EQ]     = alu_z;
          nxt_ccr[SXT_CC_SERR]   = alu_v;
          nxt_ccr[SXT_CC_BORROW] = alu_c;
          nxt_ccr[SXT_CC_BCOPY]  = alu_c;
        end
      end
      OP_SUB_WITH_CARRY: begin
        nxt_ccr[SXT_CC_MSB]    = alu_n;
        nxt_ccr[SXT_CC_EQ]     = ccr_ff[SXT_CC_EQ] & alu_z;
        nxt_ccr[SXT_CC_SERR]   = alu_v;
        nxt_ccr[SXT_CC_BORROW] = alu_c;
        nxt_ccr[SXT_CC_BCOPY]  = alu_c;
      end
      OP_XCHG: begin
        nxt_ccr[SXT_CC_MSB]    = nxt_res[31];
        nxt_ccr[SXT_CC_EQ]     = (nxt_res == 32'h0000_0000);
        nxt_ccr[SXT_CC_SERR]   = 1'b0;
        nxt_ccr[SXT_CC_BORROW] = 1'b0;
      end
      OP_TAS: begin
        nxt_ccr[SXT_CC_MSB]    = alu_dst[SXT_TAS_BIT];
        nxt_ccr[SXT_CC_EQ]     = (alu_dst[7:0] == 8'h00);
        nxt_ccr[SXT_CC_SERR]   = 1'b0;
        nxt_ccr[SXT_CC_BORROW] = 1'b0;
      end
      default: nxt_ccr = ccr_ff;
    endcase
  end

  // ****************************************
  // sequencer
  // ****************************************
  logic sw_write;
  logic fin_mem;

  // software writes are refused while an instruction is in flight
  assign sw_write = reg_wr & (state_ff == ST_IDLE);
  assign fin_mem  = (state_ff == ST_WR) & mem_ack;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (accept) begin
            if (to_dreg | to_areg) begin
              state_ff <= ST_EXEC;
            end else if (is_sub_with_carry) begin
              state_ff <= ST_RD_SRC;
            end else begin
              state_ff <= ST_RD_DST;
            end
          end
        end
        ST_EXEC: state_ff <= ST_IDLE;
        ST_RD_SRC: begin
          if (mem_berr) begin
            state_ff <= ST_IDLE;
          end else if (mem_ack) begin
            state_ff <= ST_RD_DST;
          end
        end
        ST_RD_DST: begin
          if (mem_berr) begin
            state_ff <= ST_IDLE;
          end else if (mem_ack) begin
            state_ff <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_berr | mem_ack) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // operands and destination latched when the instruction is taken
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      op_ff       <= OP_SUB_IMMEDIATE;
      size_ff     <= SXT_SZ_BYTE;
      src_ff      <= SXT_WORD_RST;
      dst_ff      <= SXT_WORD_RST;
      dst_dreg_ff <= 1'b0;
      dst_areg_ff <= 1'b0;
      dst_idx_ff  <= 3'h0;
    end else if (accept) begin
      dst_dreg_ff <= to_dreg;
      dst_areg_ff <= to_areg;
      dst_idx_ff  <= is_sub_with_carry ? f_hi : f_reg;
      dst_ff      <= to_areg ? areg_ff[f_reg] : dreg_ff[is_sub_with_carry ? f_hi : f_reg];
      size_ff     <= f_sz;
      if (is_sub_immediate) begin
        op_ff  <= OP_SUB_IMMEDIATE;
        src_ff <= nxt_imm;
      end else if (is_sub_quick) begin
        op_ff  <= OP_SUB_QUICK;
        src_ff <= nxt_quick;
        if (to_areg) begin
          size_ff <= SXT_SZ_LONG;
        end
      end else if (is_sub_with_carry) begin
        op_ff  <= OP_SUB_WITH_CARRY;
        src_ff <= dreg_ff[f_reg];
      end else if (is_xchg) begin
        op_ff   <= OP_XCHG;
        size_ff <= SXT_SZ_LONG;
      end else begin
        op_ff   <= OP_TAS;
        size_ff <= SXT_SZ_BYTE;
      end
    end else if ((state_ff == ST_RD_SRC) & mem_ack) begin
      src_ff <= mem_rdata;
    end
  end

  // ****************************************
  // memory bus master
  // ****************************************
  // a request stands until ack or bus error; the lock, raised for TAS only, spans its whole
  // read-modify-write so the arbiter cannot hand the bus over in between
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_lock_ff  <= 1'b0;
      mem_size_ff  <= SXT_SZ_BYTE;
      mem_addr_ff  <= SXT_WORD_RST;
      mem_wdata_ff <= SXT_WORD_RST;
      pend_ccr_ff  <= SXT_CCR_RST;
    end else if (mem_berr & (state_ff != ST_IDLE) & (state_ff != ST_EXEC)) begin
      mem_rd_ff   <= 1'b0;
      mem_wr_ff   <= 1'b0;
      mem_lock_ff <= 1'b0;
    end else if (accept & !(to_dreg | to_areg)) begin
      mem_rd_ff   <= 1'b1;
      mem_lock_ff <= is_tas;
      mem_size_ff <= is_tas ? SXT_SZ_BYTE : f_sz;
      mem_addr_ff <= is_sub_with_carry ? (areg_ff[f_reg] - size_bytes(f_sz)) : ea_addr;
    end else if ((state_ff == ST_RD_SRC) & mem_ack) begin
      mem_addr_ff <= areg_ff[dst_idx_ff] - size_bytes(size_ff);
    end else if ((state_ff == ST_RD_DST) & mem_ack) begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b1;
      mem_wdata_ff <= nxt_res;
      pend_ccr_ff  <= nxt_ccr;
    end else if (fin_mem) begin
      mem_wr_ff   <= 1'b0;
      mem_lock_ff <= 1'b0;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        dreg_ff[i] <= SXT_WORD_RST;
        areg_ff[i] <= SXT_WORD_RST;
      end
    end else begin
      if (sw_write & (reg_addr < SXT_RA_AREG0)) begin
        dreg_ff[reg_addr[2:0]] <= reg_wdata;
      end else if (sw_write & (reg_addr < SXT_RA_CCR)) begin
        areg_ff[reg_addr[2:0]] <= reg_wdata;
      end
      // predecrement of the source pointer when the instruction is taken
      if (accept & is_sub_with_carry & f_rm) begin
        areg_ff[f_reg] <= areg_ff[f_reg] - size_bytes(f_sz);
      end
      if ((state_ff == ST_RD_SRC) & mem_ack) begin
        areg_ff[dst_idx_ff] <= areg_ff[dst_idx_ff] - size_bytes(size_ff);
      end
      if ((state_ff == ST_EXEC) & dst_areg_ff) begin
        areg_ff[dst_idx_ff] <= nxt_res;
      end else if ((state_ff == ST_EXEC) & dst_dreg_ff) begin
        dreg_ff[dst_idx_ff] <= merge(dst_ff, nxt_res, size_ff);
      end
    end
  end

  // ****************************************
  // condition flags
  // ****************************************
  // memory forms commit only on the write ack, so a failed write leaves
  // the flags as they were
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ccr_ff <= SXT_CCR_RST;
    end else if (state_ff == ST_EXEC) begin
      ccr_ff <= nxt_ccr;
    end else if (fin_mem) begin
      ccr_ff <= pend_ccr_ff;
    end else if (sw_write & (reg_addr == SXT_RA_CCR)) begin
      ccr_ff <= reg_wdata[4:0];
    end
  end

  // ****************************************
  // status pulses and register read port
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      illegal_ff <= 1'b0;
      bus_err_ff <= 1'b0;
    end else begin
      busy_ff    <= accept | ((state_ff != ST_IDLE) & (state_ff != ST_EXEC)
                              & !mem_berr & !fin_mem);
      done_ff    <= (state_ff == ST_EXEC) | fin_mem;
      illegal_ff <= (state_ff == ST_IDLE) & instr_valid & !dec_ok;
      bus_err_ff <= mem_berr & (state_ff != ST_IDLE) & (state_ff != ST_EXEC);
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= SXT_WORD_RST;
    end else if (!reg_rd) begin
      reg_rdata_ff <= SXT_WORD_RST;
    end else if (reg_addr < SXT_RA_AREG0) begin
      reg_rdata_ff <= dreg_ff[reg_addr[2:0]];
    end else if (reg_addr < SXT_RA_CCR) begin
      reg_rdata_ff <= areg_ff[reg_addr[2:0]];
    end else if (reg_addr == SXT_RA_CCR) begin
      reg_rdata_ff <= {27'h000_0000, ccr_ff};
    end else begin
      reg_rdata_ff <= SXT_WORD_RST;
    end
  end
endmodule
`default_nettype wire

// ### bench/sxt_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sxt_exec_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        mem_rd_ff,
  input wire logic        mem_wr_ff,
  input wire logic        mem_lock_ff,
  input wire logic [1:0]  mem_size_ff,
  input wire logic [31:0] mem_addr_ff,
  input wire logic [31:0] mem_wdata_ff,
  input wire logic        mem_ack,
  input wire logic        mem_berr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic [4:0]  ccr_ff,
  input wire logic        done_ff,
  input wire logic        illegal_ff
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // rejects are single pulses and leave the flags alone
  illegal_pulse_a: assert property (illegal_ff |=> !illegal_ff) else $error("reject too long");
  illegal_keeps_ccr_a: assert property (illegal_ff |-> $stable(ccr_ff)) else $error("ccr moved");
  // read port answers only after a read strobe
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0) else $error("stray rdata");
  // a pending read request must not move its address or size under the slave
  req_hold_a: assert property (mem_rd_ff && !mem_ack && !mem_berr |=> mem_rd_ff
    && $stable(mem_addr_ff) && $stable(mem_size_ff)) else $error("request moved");
  // locked read runs straight into its write, lock never dropped
  lock_rmw_a: assert property (mem_rd_ff && mem_lock_ff && mem_ack |=> mem_wr_ff
    && mem_lock_ff) else $error("lock broken");
  mark_bit_a: assert property (mem_wr_ff && mem_lock_ff |-> mem_wdata_ff[7]) else $error("bit7 low");
  // an aborted read is not retried or followed by a write within the next three cycles
  berr_no_retry_a: assert property (mem_berr && mem_rd_ff |=> (!mem_rd_ff && !mem_wr_ff)[*3])
    else $error("retry seen");
  wr_end_done_a: assert property (mem_wr_ff && mem_ack |=> done_ff && !mem_lock_ff)
    else $error("no done");
endmodule
bind sxt_exec sxt_exec_checker i_chk (.core_clk(core_clk), .nrst(nrst), .mem_rd_ff(mem_rd_ff),
  .mem_wr_ff(mem_wr_ff), .mem_lock_ff(mem_lock_ff), .mem_size_ff(mem_size_ff),
  .mem_addr_ff(mem_addr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_ack(mem_ack),
  .mem_berr(mem_berr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .ccr_ff(ccr_ff),
  .done_ff(done_ff), .illegal_ff(illegal_ff));
`default_nettype wire

// ### bench/sxt_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sxt_exec_tb;
  import sxt_pkg::*;
  logic        core_clk, nrst, instr_valid, mem_ack, mem_berr, reg_wr, reg_rd;
  logic        mem_rd_ff, mem_wr_ff, mem_lock_ff, busy_ff, done_ff, illegal_ff, bus_err_ff;
  logic [1:0]  mem_size_ff;
  logic [4:0]  reg_addr, ccr_ff;
  logic [15:0] instr_word, ext_word0;
  logic [31:0] mem_rdata, reg_wdata, wd, q, mem_addr_ff, mem_wdata_ff, reg_rdata_ff;
  logic [2:0]  st;
  int          miscompares, total_checks;
  // ****************************************
  // bench plumbing
  // ****************************************
  sxt_exec i_dut (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_word0(ext_word0), .ext_word1(16'h0000),
    .ea_addr(32'h0000_0100), .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
    .mem_lock_ff(mem_lock_ff), .mem_size_ff(mem_size_ff), .mem_addr_ff(mem_addr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_berr(mem_berr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .ccr_ff(ccr_ff), .busy_ff(busy_ff), .done_ff(done_ff),
    .illegal_ff(illegal_ff), .bus_err_ff(bus_err_ff));
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata_ff;
  endtask
  // offer one instruction; unless mem is set, wait bounded for its outcome pulse {done, illegal, berr}
  task automatic run(input logic [15:0] iw, input logic [15:0] e0, input bit mem);
    @(posedge core_clk);
    instr_word <= iw;
    ext_word0 <= e0;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    if (!mem) fin();
  endtask
  // look once before the next edge: the outcome pulse may already be up
  task automatic fin();
    for (int i = 0; i < 40; i++) begin
      #1 st = {done_ff, illegal_ff, bus_err_ff};
      if (st != 3'h0) return;
      @(posedge core_clk);
    end
    miscompares++;
    tally_and_finish();
  endtask
  // answer the next bus request; the released data line shows the inverse value
  task automatic mem_reply(input logic berr, input logic [31:0] d);
    #1;
    for (int i = 0; i < 40 && !(mem_rd_ff | mem_wr_ff); i++) @(posedge core_clk) #1;
    if (!(mem_rd_ff | mem_wr_ff)) fin();
    wd = mem_wdata_ff;
    @(posedge core_clk);
    mem_ack <= !berr;
    mem_berr <= berr;
    mem_rdata <= d;
    @(posedge core_clk);
    mem_ack <= 1'b0;
    mem_berr <= 1'b0;
    mem_rdata <= ~d;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_sub();
    wr(SXT_RA_DREG0 + 5'h02, 32'h1234_5680);
    run(16'h0402, 16'h0081, 0);
    rd(SXT_RA_DREG0 + 5'h02);
    chk(q, 32'h1234_56ff);
    chk({27'h0, ccr_ff}, 32'h19);
    wr(SXT_RA_CCR, 32'h0);
    run(16'h5183, 16'h0, 0);
    rd(SXT_RA_DREG0 + 5'h03);
    chk(q, 32'hffff_fff8);
    chk({27'h0, ccr_ff}, 32'h19);
    wr(SXT_RA_AREG0 + 5'h01, 32'h0001_0000);
    wr(SXT_RA_CCR, 32'h0a);
    run(16'h5349, 16'h0, 0);
    rd(SXT_RA_AREG0 + 5'h01);
    chk(q, 32'h0000_ffff);
    chk({27'h0, ccr_ff}, 32'h0a);
    $display("subtract test done");
  endtask
  // borrow-in on, then zero result with equal flag preset
  task automatic t_sub_with_carry();
    for (int k = 0; k < 2; k++) begin
      wr(SXT_RA_DREG0 + 5'h04, 32'h5);
      wr(SXT_RA_DREG0 + 5'h05, 32'h5);
      wr(SXT_RA_CCR, k ? 32'h04 : 32'h14);
      run(16'h9985, 16'h0, 0);
      rd(SXT_RA_DREG0 + 5'h04);
      chk(q, k ? 32'h0 : 32'hffff_ffff);
      chk({27'h0, ccr_ff}, k ? 32'h04 : 32'h19);
    end
    $display("extend test done");
  endtask
  task automatic t_swap();
    wr(SXT_RA_DREG0 + 5'h06, 32'h8000_0001);
    wr(SXT_RA_CCR, 32'h13);
    run(16'h4846, 16'h0, 0);
    rd(SXT_RA_DREG0 + 5'h06);
    chk(q, 32'h0001_8000);
    chk({27'h0, ccr_ff}, 32'h10);
    $display("swap test done");
  endtask
  // locked mark of a memory byte, then the same with a read abort
  task automatic t_mark();
    wr(SXT_RA_CCR, 32'h13);
    run(16'h4ad0, 16'h0, 1);
    mem_reply(1'b0, 32'h0000_0001);
    chk(mem_addr_ff, 32'h0000_0100);
    chk({30'h0, mem_lock_ff, busy_ff}, 32'h3);
    mem_reply(1'b0, 32'h0);
    chk({24'h0, wd[7:0]}, 32'h81);
    fin();
    chk({27'h0, ccr_ff}, 32'h10);
    chk({30'h0, mem_lock_ff, busy_ff}, 32'h0);
    run(16'h4ad0, 16'h0, 1);
    mem_reply(1'b1, 32'h0);
    fin();
    chk({29'h0, st}, 32'h1);
    chk({27'h0, ccr_ff}, 32'h10);
    $display("mark test done");
  endtask
  task automatic t_bad();
    logic [15:0] codes [4] = '{16'h04c2, 16'h0449, 16'h53ba, 16'h5309};
    foreach (codes[i]) begin
      run(codes[i], 16'h0, 0);
      chk({29'h0, st}, 32'h2);
    end
    rd(5'h11);
    chk(q, 32'h0);
    $display("reject test done");
  endtask
  initial begin
    nrst = 1'b0;
    {instr_valid, mem_ack, mem_berr, reg_wr, reg_rd} = 5'h00;
    {instr_word, ext_word0, reg_addr} = 37'h0;
    {mem_rdata, reg_wdata} = 64'h0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_sub();
    t_sub_with_carry();
    t_swap();
    t_mark();
    t_bad();
    tally_and_finish();
  end
endmodule
`default_nettype wire
